// ### hdl/ssd_pkg.sv
// Constants, types and display codes for the servo status display and editor
package ssd_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ        = 100_000_000;  // System clock rate
    localparam int unsigned HOLD_TIME_MS  = 1000;         // Long press length, ms
    localparam int unsigned HOLD_CYCLES   = CLK_HZ / 1000 * HOLD_TIME_MS;
    localparam int unsigned REFRESH_US    = 1000;         // Display update period, us
    localparam int unsigned REFRESH_CYCLES = CLK_HZ / 1_000_000 * REFRESH_US;
    localparam int unsigned FLASH_MS      = 250;          // Flash half period, ms
    localparam int unsigned FLASH_CYCLES  = CLK_HZ / 1000 * FLASH_MS;

    // ************************************************************
    // Threshold defaults
    // ************************************************************
    localparam logic [15:0] SPEED_MATCH_DEF = 16'h000A;   // 10 per minute
    localparam logic [15:0] ROTATION_DEF    = 16'h0014;   // 20 per minute
    localparam logic [15:0] POS_WINDOW_DEF  = 16'h0007;   // 7 pulses
    localparam logic [15:0] TORQUE_REF_DEF  = 16'h000A;   // 10 percent of rated

    // ************************************************************
    // Parameter store
    // ************************************************************
    localparam int unsigned NUM_PARAMS = 16;               // Stored parameters
    localparam int unsigned NUM_DIGITS = 5;                // Display digits
    localparam logic [3:0]  DIGIT_MAX  = 4'h9;             // Decimal digit top
    localparam logic [3:0]  HEX_MAX    = 4'hF;             // Function digit top
    localparam logic [3:0]  PNUM_MAX   = 4'hF;             // Highest parameter number

    // ************************************************************
    // Indicator bit positions
    // ************************************************************
    localparam int unsigned IND_CTRL_PWR  = 0;
    localparam int unsigned IND_BBLOCK    = 1;
    localparam int unsigned IND_MATCH_POS = 2;  // Speed match or position done
    localparam int unsigned IND_ROTATION  = 3;
    localparam int unsigned IND_REF_SPD   = 4;  // Speed reference or ref pulse
    localparam int unsigned IND_REF_TRQ   = 5;  // Torque reference or clear input
    localparam int unsigned IND_PWR_READY = 6;
    localparam int unsigned IND_W         = 7;

    // ************************************************************
    // Status codes
    // ************************************************************
    localparam logic [2:0] CODE_BBLOCK = 3'h0;
    localparam logic [2:0] CODE_RUN    = 3'h1;
    localparam logic [2:0] CODE_FWD    = 3'h2;
    localparam logic [2:0] CODE_REV    = 3'h3;
    localparam logic [2:0] CODE_ALARM  = 3'h4;

    // Basic modes, in key order
    typedef enum logic [3:0] {
        MODE_STATUS  = 4'h1,
        MODE_AUX     = 4'h2,
        MODE_PARAM   = 4'h4,
        MODE_MONITOR = 4'h8
    } ssd_mode_t;

    // Parameter editor states
    typedef enum logic [3:0] {
        ED_NUMBER = 4'h1,   // Parameter number view
        ED_DATA   = 4'h2,   // Data view, editing
        ED_STORED = 4'h4,   // Data stored, flashing
        ED_IDLE   = 4'h8    // Unused spare
    } ssd_edit_t;

endpackage

// ### hdl/ssd_top.sv
// Servo status indicators, status codes and key driven parameter editor
`timescale 1ns/1ps
// How it works
// - Control power lights its indicator always
// - Baseblock lit in baseblock, dark servo on
// - Speed coincidence when speed error within threshold
// - Rotation detect when speed above threshold
// - Speed reference lit above rotation threshold
// - Torque reference lit above ten percent
// - Power ready lit when main power normal
// - Positioning done when error below window
// - Reference pulse lit while pulses arrive
// - Clear indicator follows counter clear input
// - Baseblock code while servo off
// - Run code while servo on
// - Forward prohibited code when forward limit off
// - Reverse prohibited code when reverse limit off
// - Alarm replaces code, shows alarm number
// - Value and function selection parameter kinds
// - Each of five digits separately selectable
// - Handheld arrows pick flashing digit, change value
// - Handheld enter shows data, then stores, flashes
// - One more data press returns number view
// - Panel shift held one second shows data
// - Panel arrows step parameter number
// - Mode key cycles status, aux, param, monitor
// - Panel up plus down resets alarm in status mode
// - Short shift press moves digit left
// - Long shift while editing stores, flashes
module ssd_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        position_mode,      // High: position control mode
    input  wire logic        ctrl_power_on,
    input  wire logic        servo_on,
    input  wire logic        main_power_ok,
    input  wire logic [15:0] motor_speed,        // Absolute, per minute
    input  wire logic [15:0] speed_reference,    // Absolute, per minute
    input  wire logic [15:0] torque_reference,   // Percent of rated
    input  wire logic [15:0] position_error,     // Absolute, pulses
    input  wire logic        ref_pulse_active,
    input  wire logic        error_clear_in,
    input  wire logic        forward_limit_input, // Low: limit off
    input  wire logic        reverse_limit_input,
    input  wire logic        alarm_active,
    input  wire logic [7:0]  alarm_number,
    input  wire logic [15:0] speed_match_threshold,
    input  wire logic [15:0] rotation_threshold,
    input  wire logic [15:0] position_window,
    input  wire logic [15:0] param_is_function,  // One bit per parameter
    input  wire logic        panel_mode_key,     // Key pulses, one cycle each
    input  wire logic        panel_up_key,       // Panel arrows are levels
    input  wire logic        panel_down_key,
    input  wire logic        panel_shift_key,    // Level, held while pressed
    input  wire logic        handheld_mode_key,
    input  wire logic        handheld_enter_key,
    input  wire logic        handheld_up_key,
    input  wire logic        handheld_down_key,
    input  wire logic        handheld_left_key,
    input  wire logic        handheld_right_key,
    output logic [6:0]       indicator_q,
    output logic [2:0]       status_code_q,
    output logic [7:0]       alarm_number_q,
    output logic [3:0]       mode_q,
    output logic [3:0]       param_number_q,
    output logic [19:0]      display_digits_q,   // Five hex digits, digit 0 low
    output logic [4:0]       digit_flash_q,      // Flashing digit, one hot
    output logic             display_blank_q,    // Whole display flash phase
    output logic             view_data_q,        // High: data view shown
    output logic             alarm_reset_q       // One cycle pulse
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Wrap a digit upward within its range
    function automatic logic [3:0] dig_up(input logic [3:0] v, input logic [3:0] top);
        dig_up = (v >= top) ? 4'h0 : v + 4'h1;
    endfunction

    // Wrap a digit downward within its range
    function automatic logic [3:0] dig_dn(input logic [3:0] v, input logic [3:0] top);
        dig_dn = (v == 4'h0) ? top : v - 4'h1;
    endfunction

    // ************************************************************
    // Status indicators and codes
    // ************************************************************
    logic [16:0] spd_diff;        // Signed speed difference
    logic [15:0] spd_abs;         // Absolute speed difference
    logic [6:0]  ind_d;           // Next indicator pattern
    logic [2:0]  code_d;          // Next status code
    logic        ind_match_w;
    logic        ind_ref_w;
    logic        ind_trq_w;

    assign spd_diff = {1'b0, motor_speed} - {1'b0, speed_reference};
    assign spd_abs  = spd_diff[16] ? 16'(-spd_diff) : spd_diff[15:0];

    // Mode dependent indicators: speed coincidence vs position done
    assign ind_match_w = position_mode ? (position_error < position_window)
                                       : (spd_abs <= speed_match_threshold);
    // Speed reference vs reference pulse
    assign ind_ref_w   = position_mode ? ref_pulse_active
                                       : (speed_reference > rotation_threshold);
    // Torque reference vs counter clear
    assign ind_trq_w   = position_mode ? error_clear_in
                                       : (torque_reference > ssd_pkg::TORQUE_REF_DEF);

    always_comb begin
        ind_d = '0;
        ind_d[ssd_pkg::IND_CTRL_PWR]  = ctrl_power_on;
        ind_d[ssd_pkg::IND_BBLOCK]    = ~servo_on;
        ind_d[ssd_pkg::IND_MATCH_POS] = ind_match_w;
        ind_d[ssd_pkg::IND_ROTATION]  = motor_speed > rotation_threshold;
        ind_d[ssd_pkg::IND_REF_SPD]   = ind_ref_w;
        ind_d[ssd_pkg::IND_REF_TRQ]   = ind_trq_w;
        ind_d[ssd_pkg::IND_PWR_READY] = main_power_ok;
    end

    // Limits outrank run state so the operator sees why motion stops
    always_comb begin
        if (alarm_active) begin
            code_d = ssd_pkg::CODE_ALARM;
        end else if (!forward_limit_input) begin
            code_d = ssd_pkg::CODE_FWD;
        end else if (!reverse_limit_input) begin
            code_d = ssd_pkg::CODE_REV;
        end else if (servo_on) begin
            code_d = ssd_pkg::CODE_RUN;
        end else begin
            code_d = ssd_pkg::CODE_BBLOCK;
        end
    end

    // Display update divider
    logic [$clog2(ssd_pkg::REFRESH_CYCLES)-1:0] ref_cnt_q;
    logic                                        refresh_w;
    assign refresh_w = (ref_cnt_q == '0);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_cnt_q <= '0;
        end else if (refresh_w) begin
            ref_cnt_q <= $bits(ref_cnt_q)'(ssd_pkg::REFRESH_CYCLES - 1);
        end else begin
            ref_cnt_q <= ref_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            indicator_q    <= '0;
            status_code_q  <= ssd_pkg::CODE_BBLOCK;
            alarm_number_q <= '0;
        end else if (refresh_w) begin
            indicator_q    <= ind_d;
            status_code_q  <= code_d;
            alarm_number_q <= alarm_active ? alarm_number : 8'h00;
        end
    end

    // ************************************************************
    // Key decoding
    // ************************************************************
    logic        shift_prev_q;                    // Shift key last cycle
    logic        long_done_q;                     // Long press already acted
    logic [$clog2(ssd_pkg::HOLD_CYCLES+1)-1:0] hold_cnt_q;
    logic        long_w;                          // Long press reached, pulse
    logic        short_w;                         // Short press released, pulse
    logic        pup_prev_q;
    logic        pdn_prev_q;
    logic        p_up_w;
    logic        p_dn_w;
    logic        p_both_w;
    logic        mode_key_w;

    assign long_w  = panel_shift_key && !long_done_q &&
                     (hold_cnt_q == $bits(hold_cnt_q)'(ssd_pkg::HOLD_CYCLES - 1));
    assign short_w = shift_prev_q && !panel_shift_key && !long_done_q;

    // Up and down together are a reset, never a step
    assign p_both_w = panel_up_key && panel_down_key && !(pup_prev_q && pdn_prev_q);
    assign p_up_w   = panel_up_key && !pup_prev_q && !panel_down_key;
    assign p_dn_w   = panel_down_key && !pdn_prev_q && !panel_up_key;
    assign mode_key_w = panel_mode_key | handheld_mode_key;

    // Shift hold timer; long acts once per press
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hold_cnt_q   <= '0;
            long_done_q  <= 1'b0;
            shift_prev_q <= 1'b0;
            pup_prev_q   <= 1'b0;
            pdn_prev_q   <= 1'b0;
        end else begin
            shift_prev_q <= panel_shift_key;
            pup_prev_q   <= panel_up_key;
            pdn_prev_q   <= panel_down_key;
            hold_cnt_q   <= (panel_shift_key && !long_w) ? hold_cnt_q + 1'b1 : '0;
            long_done_q  <= panel_shift_key && (long_done_q || long_w);
        end
    end

    // ************************************************************
    // Mode and editor
    // ************************************************************
    ssd_pkg::ssd_mode_t mode_st_q;
    ssd_pkg::ssd_edit_t ed_q;
    logic [19:0] store_q [ssd_pkg::NUM_PARAMS];   // Parameter values
    logic [19:0] work_q;                          // Data being edited
    logic [4:0]  cur_q;                           // Selected digit, one hot
    logic [4:0]  cur_left_w;
    logic [4:0]  cur_right_w;
    logic [3:0]  top_w;                           // Digit range top
    logic [19:0] work_up_w;
    logic [19:0] work_dn_w;
    logic        in_param_w;
    logic        enter_w;                         // Open or store
    logic        step_up_w;
    logic        step_dn_w;

    assign in_param_w = (mode_st_q == ssd_pkg::MODE_PARAM);
    // function kind edits in hex digits, value kind in decimal
    assign top_w = param_is_function[param_number_q] ? ssd_pkg::HEX_MAX
                                                     : ssd_pkg::DIGIT_MAX;
    assign cur_left_w  = {cur_q[3:0], cur_q[4]};
    assign cur_right_w = {cur_q[0], cur_q[4:1]};
    assign enter_w   = handheld_enter_key | long_w;
    assign step_up_w = handheld_up_key | p_up_w;
    assign step_dn_w = handheld_down_key | p_dn_w;

    genvar gi;
    generate
        for (gi = 0; gi < ssd_pkg::NUM_DIGITS; gi++) begin : g_dig
            assign work_up_w[gi*4 +: 4] = cur_q[gi] ? dig_up(work_q[gi*4 +: 4], top_w)
                                                    : work_q[gi*4 +: 4];
            assign work_dn_w[gi*4 +: 4] = cur_q[gi] ? dig_dn(work_q[gi*4 +: 4], top_w)
                                                    : work_q[gi*4 +: 4];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_st_q <= ssd_pkg::MODE_STATUS;
        end else if (mode_key_w && (ed_q == ssd_pkg::ED_NUMBER)) begin
            case (mode_st_q)
                ssd_pkg::MODE_STATUS:  mode_st_q <= ssd_pkg::MODE_AUX;
                ssd_pkg::MODE_AUX:     mode_st_q <= ssd_pkg::MODE_PARAM;
                ssd_pkg::MODE_PARAM:   mode_st_q <= ssd_pkg::MODE_MONITOR;
                default:               mode_st_q <= ssd_pkg::MODE_STATUS;
            endcase
        end
    end

    // Editor sequence; parameter number view, data view, stored
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ed_q           <= ssd_pkg::ED_NUMBER;
            param_number_q <= '0;
            work_q         <= '0;
            cur_q          <= 5'h01;
        end else if (in_param_w) begin
            case (ed_q)
                ssd_pkg::ED_NUMBER: begin
                    if (enter_w) begin
                        ed_q   <= ssd_pkg::ED_DATA;
                        work_q <= store_q[param_number_q];
                        cur_q  <= 5'h01;
                    end else if (step_up_w) begin
                        param_number_q <= param_number_q + 4'h1;
                    end else if (step_dn_w) begin
                        param_number_q <= param_number_q - 4'h1;
                    end
                end
                ssd_pkg::ED_DATA: begin
                    if (enter_w) begin
                        ed_q <= ssd_pkg::ED_STORED;
                    end else if (handheld_left_key || short_w) begin
                        cur_q <= cur_left_w;
                    end else if (handheld_right_key) begin
                        cur_q <= cur_right_w;
                    end else if (step_up_w) begin
                        work_q <= work_up_w;
                    end else if (step_dn_w) begin
                        work_q <= work_dn_w;
                    end
                end
                ssd_pkg::ED_STORED: begin
                    if (enter_w) begin
                        ed_q <= ssd_pkg::ED_NUMBER;
                    end
                end
                default: ed_q <= ssd_pkg::ED_NUMBER;
            endcase
        end else begin
            ed_q <= ssd_pkg::ED_NUMBER;
        end
    end

    // Parameter store written once, on the storing press
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < ssd_pkg::NUM_PARAMS; i++) begin
                store_q[i] <= '0;
            end
        end else if (in_param_w && (ed_q == ssd_pkg::ED_DATA) && enter_w) begin
            store_q[param_number_q] <= work_q;
        end
    end

    // ************************************************************
    // Display outputs
    // ************************************************************
    logic [$clog2(ssd_pkg::FLASH_CYCLES)-1:0] fl_cnt_q;
    logic                                      fl_ph_q;

    // Flash phase divider
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fl_cnt_q <= '0;
            fl_ph_q  <= 1'b0;
        end else if (fl_cnt_q == $bits(fl_cnt_q)'(ssd_pkg::FLASH_CYCLES - 1)) begin
            fl_cnt_q <= '0;
            fl_ph_q  <= ~fl_ph_q;
        end else begin
            fl_cnt_q <= fl_cnt_q + 1'b1;
        end
    end

    // Registered copies of the view; alarm reset pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q           <= ssd_pkg::MODE_STATUS;
            display_digits_q <= '0;
            digit_flash_q    <= '0;
            display_blank_q  <= 1'b0;
            view_data_q      <= 1'b0;
            alarm_reset_q    <= 1'b0;
        end else begin
            mode_q           <= mode_st_q;
            view_data_q      <= (ed_q != ssd_pkg::ED_NUMBER);
            display_digits_q <= (ed_q == ssd_pkg::ED_NUMBER) ? {16'h0000, param_number_q}
                                                             : work_q;
            digit_flash_q    <= (ed_q == ssd_pkg::ED_DATA) ? cur_q : 5'h00;
            display_blank_q  <= (ed_q == ssd_pkg::ED_STORED) && fl_ph_q;
            // up and down in status mode
            alarm_reset_q    <= p_both_w && (mode_st_q == ssd_pkg::MODE_STATUS);
        end
    end

endmodule

// ### tb/ssd_monitor.sv
// Port checker for the status display and parameter editor
`timescale 1ns/1ps
module ssd_monitor (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       panel_mode_key,
    input wire logic       panel_up_key,
    input wire logic       panel_down_key,
    input wire logic       handheld_mode_key,
    input wire logic       handheld_enter_key,
    input wire logic [6:0] indicator_q,
    input wire logic [2:0] status_code_q,
    input wire logic [7:0] alarm_number_q,
    input wire logic [3:0] mode_q,
    input wire logic [3:0] param_number_q,
    input wire logic [4:0] digit_flash_q,
    input wire logic       view_data_q,
    input wire logic       alarm_reset_q
);
    // ****************************************
    // Properties, one clock domain
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_alarm_code; alarm_number_q != 8'h00 |-> status_code_q == ssd_pkg::CODE_ALARM;
    endproperty
    a_alarm_code: assert property (p_alarm_code) else $error("alarm number without code");
    property p_run_dark; status_code_q == ssd_pkg::CODE_RUN |-> !indicator_q[ssd_pkg::IND_BBLOCK];
    endproperty
    a_run_dark: assert property (p_run_dark) else $error("baseblock lit while running");
    property p_mode_step; handheld_mode_key && mode_q == ssd_pkg::MODE_STATUS
        |-> ##2 mode_q == ssd_pkg::MODE_AUX;
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode key did not advance mode");
    // A mode change needs a mode key two edges earlier
    property p_mode_hold; !$past(panel_mode_key) && !$past(handheld_mode_key) |=> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without a key");
    property p_enter_data; handheld_enter_key && mode_q == ssd_pkg::MODE_PARAM && !view_data_q
        |-> ##2 view_data_q && digit_flash_q == 5'h01;
    endproperty
    a_enter_data: assert property (p_enter_data) else $error("enter did not open data");
    property p_flash_view; $onehot0(digit_flash_q) && (view_data_q || digit_flash_q == 5'h00);
    endproperty
    a_flash_view: assert property (p_flash_view) else $error("bad digit flash");
    property p_panel_step; $rose(panel_up_key) && !panel_down_key && mode_q == ssd_pkg::MODE_PARAM
        && !view_data_q |-> ##2 param_number_q == $past(param_number_q, 2) + 4'h1;
    endproperty
    a_panel_step: assert property (p_panel_step) else $error("panel up did not step");
    property p_alarm_reset; $rose(panel_up_key) && $rose(panel_down_key)
        && mode_q == ssd_pkg::MODE_STATUS |-> ##[1:3] alarm_reset_q;
    endproperty
    a_alarm_reset: assert property (p_alarm_reset) else $error("no alarm reset pulse");
endmodule
bind ssd_top ssd_monitor i_mon (.clk, .nrst, .panel_mode_key, .panel_up_key, .panel_down_key,
    .handheld_mode_key, .handheld_enter_key, .indicator_q, .status_code_q, .alarm_number_q,
    .mode_q, .param_number_q, .digit_flash_q, .view_data_q, .alarm_reset_q);

// ### tb/ssd_operator.sv
// Operator model pressing and releasing the panel and keypad keys
`timescale 1ns/1ps
module ssd_operator (
    input  wire logic clk,
    output logic [9:0] keys_q   // Bit order follows the bench key map
);
    initial keys_q = 10'h000;
    task automatic press(input logic [9:0] mask, input int len);
        @(posedge clk);
        #1 keys_q = mask;
        repeat (len) @(posedge clk);
        #1 keys_q = 10'h000;
        // Let the editor answer before the next press
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule

// ### tb/ssd_top_tb.sv
// Self-checking bench for the status display and parameter editor
`timescale 1ns/1ps
module ssd_top_tb;
    logic clk, nrst, position_mode, ctrl_power_on, servo_on, main_power_ok, ref_pulse_active;
    logic error_clear_in, forward_limit_input, reverse_limit_input, alarm_active;
    logic [15:0] motor_speed, speed_reference, torque_reference, position_error;
    logic [15:0] speed_match_threshold, rotation_threshold, position_window, param_is_function;
    logic [7:0]  alarm_number, alarm_number_q;
    logic [9:0]  keys;   // Key map: 0 mode,1 up,2 down,3 shift,4..9 handheld mode..right
    logic [6:0]  indicator_q;
    logic [2:0]  status_code_q;
    logic [3:0]  mode_q, param_number_q;
    logic [19:0] display_digits_q;
    logic [4:0]  digit_flash_q;
    logic        view_data_q, alarm_reset_q, display_blank_q;
    int          fail_count, n_tests, seen_rst;
    ssd_top i_dut (.clk, .nrst, .position_mode, .ctrl_power_on, .servo_on, .main_power_ok,
        .motor_speed, .speed_reference, .torque_reference, .position_error, .ref_pulse_active,
        .error_clear_in, .forward_limit_input, .reverse_limit_input, .alarm_active,
        .alarm_number, .speed_match_threshold, .rotation_threshold, .position_window,
        .param_is_function, .panel_mode_key(keys[0]), .panel_up_key(keys[1]),
        .panel_down_key(keys[2]), .panel_shift_key(keys[3]), .handheld_mode_key(keys[4]),
        .handheld_enter_key(keys[5]), .handheld_up_key(keys[6]), .handheld_down_key(keys[7]),
        .handheld_left_key(keys[8]), .handheld_right_key(keys[9]), .indicator_q,
        .status_code_q, .alarm_number_q, .mode_q, .param_number_q, .display_digits_q,
        .digit_flash_q, .display_blank_q, .view_data_q, .alarm_reset_q);
    ssd_operator i_op (.clk, .keys_q(keys));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count alarm reset pulses seen on the output
    always @(posedge clk) if (alarm_reset_q === 1'b1) seen_rst++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Condition inputs; limits and alarm biased so every code turns up
    task automatic drive(input logic [31:0] r);
        {position_mode, ctrl_power_on, servo_on, main_power_ok, ref_pulse_active} = r[4:0];
        error_clear_in = r[5];
        alarm_active = &r[8:6];
        forward_limit_input = |r[10:9];
        reverse_limit_input = |r[12:11];
        speed_match_threshold = ssd_pkg::SPEED_MATCH_DEF + 16'(r[14:13]);
        rotation_threshold = ssd_pkg::ROTATION_DEF + 16'(r[16:15]);
        position_window = ssd_pkg::POS_WINDOW_DEF + 16'(r[18:17]);
        alarm_number = r[31:24];
        motor_speed = 16'($urandom % 40);
        speed_reference = 16'($urandom % 40);
        torque_reference = 16'($urandom % 20);
        position_error = 16'($urandom % 14);
        param_is_function = 16'h0004;
    endtask
    // ****************************************
    // Indicators and codes, fresh refresh after each short reset
    // ****************************************
    task automatic cond_test();
        logic [6:0] ei;
        logic [2:0] ec;
        int d;
        @(posedge clk);
        #1 drive($urandom);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk);
        #1 d = int'(motor_speed) - int'(speed_reference);
        d = (d < 0) ? -d : d;
        ei = {main_power_ok,
              position_mode ? error_clear_in : torque_reference > ssd_pkg::TORQUE_REF_DEF,
              position_mode ? ref_pulse_active : speed_reference > rotation_threshold,
              motor_speed > rotation_threshold,
              position_mode ? position_error < position_window : d <= int'(speed_match_threshold),
              !servo_on, ctrl_power_on};
        ec = alarm_active ? ssd_pkg::CODE_ALARM : !forward_limit_input ? ssd_pkg::CODE_FWD :
             !reverse_limit_input ? ssd_pkg::CODE_REV :
             servo_on ? ssd_pkg::CODE_RUN : ssd_pkg::CODE_BBLOCK;
        chk(32'(indicator_q), 32'(ei));
        chk(32'(status_code_q), 32'(ec));
        chk(32'(alarm_number_q), alarm_active ? 32'(alarm_number) : 32'h0);
    endtask
    task automatic key(input int b, input int n, input int len);
        repeat (n) i_op.press(10'(1 << b), len);
    endtask
    initial begin
        void'($urandom(32'h0000B1CA));
        fail_count = 0;
        n_tests = 0;
        seen_rst = 0;
        nrst = 1'b0;
        drive(32'h0);
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (16) cond_test();
        i_op.press(10'h006, 1);
        chk(32'(seen_rst), 32'h1);
        // Mode order, alternating panel and keypad keys
        for (int i = 1; i <= 4; i++) begin
            key((i % 2 == 1) ? 4 : 0, 1, 1);
            chk(32'(mode_q), 32'(1 << (i % 4)));
        end
        key(7, 1, 1);
        key(0, 2, 1);
        key(7, 1, 1);
        chk(32'(param_number_q), 32'hF);
        key(1, 3, 1);
        chk({view_data_q, display_digits_q}, 32'h00002);
        key(5, 1, 1);
        chk({view_data_q, digit_flash_q, display_digits_q}, {6'h0, 1'b1, 5'h01, 20'h0});
        key(6, 15, 1);
        key(8, 1, 1);
        key(6, 3, 1);
        chk({view_data_q, digit_flash_q, display_digits_q}, 32'h0220003F);
        key(9, 1, 1);
        key(3, 1, 3);
        chk(32'(digit_flash_q), 32'h02);
        key(5, 1, 1);
        chk({display_blank_q, view_data_q, digit_flash_q}, 32'h20);
        key(5, 1, 1);
        chk({view_data_q, display_digits_q}, 32'h00002);
        key(5, 1, 1);
        key(4, 1, 1);
        chk({mode_q, display_digits_q}, {8'h0, 4'h4, 20'h0003F});
        key(5, 2, 1);
        key(6, 1, 1);
        key(5, 1, 1);
        key(6, 11, 1);
        key(2, 2, 1);
        chk({view_data_q, param_number_q, display_digits_q}, 32'h01300009);
        conclude();
    end
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        chk(32'h0, 32'h1);
        conclude();
    end
endmodule
